/* rtl/irq_status_map.svh */
// Register offsets, field positions and reset values of the request and error block.
`ifndef IRQ_STATUS_MAP_SVH
`define IRQ_STATUS_MAP_SVH
`define OFS_MAIN_IRQ_ENABLE 8'h02
`define OFS_AUX_IRQ_ENABLE 8'h03
`define OFS_MAIN_IRQ_REQUEST 8'h04
`define OFS_AUX_IRQ_REQUEST 8'h05
`define OFS_ERROR_STATUS 8'h06
`define OFS_IRQ_STATUS 8'h07
`define MARKER_BIT 7
`define MAIN_TX_BIT 6
`define MAIN_RX_BIT 5
`define MAIN_IDLE_BIT 4
`define MAIN_HI_BIT 3
`define MAIN_LO_BIT 2
`define MAIN_ERR_BIT 1
`define MAIN_TIMER_BIT 0
`define AUX_EDGE_BIT 4
`define AUX_CRC_BIT 2
`define AUX_VALID_MASK 8'h14
`define ERR_WRITE_BIT 7
`define ERR_HEAT_BIT 6
`define ERR_OVFL_BIT 4
`define ERR_COLL_BIT 3
`define ERR_CRC_BIT 2
`define ERR_PARITY_BIT 1
`define ERR_FRAME_BIT 0
`define ERR_VALID_MASK 8'hDF
`define MAIN_REQ_RESET 8'h14
`define MAIN_EN_RESET 8'h80
`define ZERO_BYTE 8'h00
`define INVERT_BIT 7
`define STATUS_IRQ_BIT 4
`define CMD_IDLE 4'h0
`define EDGE_SETTLE 2'h3
`define ONE_HOLD 2'h1
`define ZERO_HOLD 2'h0
`endif

/* rtl/irq_status_pkg.sv */
// Types shared by the request and error block.
package irq_status_pkg;
	typedef enum logic [1:0] {
		RATE_106,
		RATE_212,
		RATE_424,
		RATE_848
	} rx_rate_t;
	typedef enum logic {
		BUS_IDLE,
		BUS_ACK
	} bus_state_t;
endpackage : irq_status_pkg

/* rtl/irq_and_error_status.sv */
// Interrupt request latching, error status and IRQ pin logic behind a Wishbone slave.
// Operation
// [RULE1] Main marker bit selects set or clear
// [RULE2] Aux marker bit selects set or clear
// [RULE3] Transmit done sets main bit 6
// [RULE4] Valid receive end sets main bit 5
// [RULE5] Require-data option needs FIFO bytes present
// [RULE6] Command termination to idle sets bit 4
// [RULE7] Unknown command returns idle, sets bit 4
// [RULE8] Host-started idle command sets no flag
// [RULE9] FIFO high rise latches main bit 3
// [RULE10] FIFO low rise latches main bit 2
// [RULE11] Any error bit sets main bit 1
// [RULE12] Timer reaching zero sets main bit 0
// [RULE13] Input edges set aux bit 4
// [RULE14] Checksum command finished sets aux bit 2
// [RULE15] Illegal FIFO write sets error bit 7
// [RULE16] Overheat sets bit 6, drivers off
// [RULE17] Write to full FIFO sets bit 4
// [RULE18] Collision at 106 only, cleared at start
// [RULE19] Failed checked CRC sets bit 2
// [RULE20] Parity fail at 106 sets bit 1
// [RULE21] Bad frame or auth count sets bit 0
// [RULE22] Command start clears errors except overheat
// [RULE23] Enabled requests only reach IRQ
// [RULE24] Polarity bit inverts IRQ pin
// [RULE25] Marker write touches only written ones
// [RULE26] Reserved bits read zero, ignore writes
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
`include "irq_status_map.svh"

module irq_and_error_status (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Events from transmitter, receiver, timer and checksum unit.
	input wire logic tx_last_bit_sent,
	input wire logic rx_valid_end,
	input wire logic fifo_has_data,
	input wire logic rx_require_data_option,
	input wire logic rx_checksum_enable,
	input wire logic timer_reached_zero,
	input wire logic checksum_all_processed,
	input wire logic rx_startup,
	input wire irq_status_pkg::rx_rate_t rx_rate,
	input wire logic anticollision_active,
	input wire logic bit_collision_seen,
	input wire logic checksum_mismatch,
	input wire logic parity_mismatch,
	input wire logic bad_start_of_frame,
	input wire logic auth_byte_count_bad,
	// FIFO activity.
	input wire logic fifo_high_status,
	input wire logic fifo_low_status,
	input wire logic host_fifo_write,
	input wire logic internal_fifo_write,
	input wire logic fifo_full,
	input wire logic rf_response_window,
	// Command sequencer.
	input wire logic [3:0] active_command,
	input wire logic command_start,
	input wire logic [3:0] started_command,
	input wire logic started_command_known,
	input wire logic command_done,
	input wire logic card_authentication_command,
	input wire logic checksum_compute_command,
	// Asynchronous pins.
	input wire logic contactless_serial_input,
	input wire logic overheat_alarm,
	// Results.
	output logic force_idle_command,
	output logic antenna_driver_off,
	output logic irq_pin
);

	// Registered state.
	logic [7:0] main_irq_request;
	logic [7:0] aux_irq_request;
	logic [7:0] error_status;
	logic [7:0] main_irq_enable;
	logic [7:0] aux_irq_enable;
	logic [2:0] contactless_serial_input_sync;
	logic [1:0] heat_sync;
	logic prev_high;
	logic prev_low;
	logic [1:0] edge_hold;
	logic ack;
	logic [31:0] rdata;
	logic force_idle;
	logic drivers_off;
	logic pin;

	// Next values.
	logic [7:0] next_main_irq_request;
	logic [7:0] next_aux_irq_request;
	logic [7:0] next_error_status;
	logic [7:0] next_main_irq_enable;
	logic [7:0] next_aux_irq_enable;
	logic next_ack;
	logic [31:0] next_rdata;
	logic next_force_idle;
	logic next_drivers_off;
	logic next_pin;
	logic [2:0] next_contactless_serial_input_sync;
	logic [1:0] next_heat_sync;
	logic next_prev_high;
	logic next_prev_low;
	logic [1:0] next_edge_hold;

	// Decoded bus and event terms.
	logic access;
	logic wr_byte;
	logic [7:0] wbyte;
	logic irq_combined;
	logic contactless_serial_input_edge;
	logic heat;
	logic is_106;

	// The marker write covers only cycles with no ack pending, so a held request acts again every second cycle.
	assign access = wb_cyc_i && wb_stb_i && !ack;
	assign wr_byte = access && wb_we_i && wb_sel_i[0];
	assign wbyte = wb_dat_i[7:0];
	assign contactless_serial_input_edge = (contactless_serial_input_sync[2] ^ contactless_serial_input_sync[1]) && (edge_hold == `ZERO_HOLD); // [RULE13]
	assign heat = heat_sync[1];
	assign is_106 = (rx_rate == irq_status_pkg::RATE_106);
	assign irq_combined = |((main_irq_request & main_irq_enable) // [RULE23]
		| ({1'b0, aux_irq_request[6:0]} & {1'b0, aux_irq_enable[6:0]} & `AUX_VALID_MASK));

	// Error status; a hardware set in the same cycle as a command start wins.
	always_comb begin
		next_error_status = error_status;
		if (command_start) begin
			next_error_status = error_status & (8'h01 << `ERR_HEAT_BIT); // [RULE22]
		end
		if (rx_startup) begin
			next_error_status[`ERR_COLL_BIT] = 1'b0; // [RULE18]
			next_error_status[`ERR_CRC_BIT] = 1'b0; // [RULE19]
			next_error_status[`ERR_PARITY_BIT] = 1'b0; // [RULE20]
			next_error_status[`ERR_FRAME_BIT] = 1'b0; // [RULE21]
		end
		if (host_fifo_write && (card_authentication_command || rf_response_window)) begin
			next_error_status[`ERR_WRITE_BIT] = 1'b1; // [RULE15]
		end
		if (heat) begin
			next_error_status[`ERR_HEAT_BIT] = 1'b1; // [RULE16]
		end
		if ((host_fifo_write || internal_fifo_write) && fifo_full) begin
			next_error_status[`ERR_OVFL_BIT] = 1'b1; // [RULE17]
		end
		if (!is_106) begin
			next_error_status[`ERR_COLL_BIT] = 1'b0; // [RULE18]
		end else if (bit_collision_seen && anticollision_active) begin
			next_error_status[`ERR_COLL_BIT] = 1'b1; // [RULE18]
		end
		if (rx_checksum_enable && checksum_mismatch) begin
			next_error_status[`ERR_CRC_BIT] = 1'b1; // [RULE19]
		end
		if (is_106 && parity_mismatch) begin
			next_error_status[`ERR_PARITY_BIT] = 1'b1; // [RULE20]
		end
		if ((is_106 && bad_start_of_frame)
			|| (card_authentication_command && auth_byte_count_bad)) begin
			next_error_status[`ERR_FRAME_BIT] = 1'b1; // [RULE21]
		end
		next_error_status = next_error_status & `ERR_VALID_MASK; // [RULE26]
	end

	// Request registers: marker writes first, hardware sets last so they win.
	always_comb begin
		next_main_irq_request = main_irq_request;
		next_aux_irq_request = aux_irq_request;
		next_main_irq_enable = main_irq_enable;
		next_aux_irq_enable = aux_irq_enable;
		next_force_idle = 1'b0;
		if (wr_byte && wb_adr_i == `OFS_MAIN_IRQ_REQUEST) begin
			if (wbyte[`MARKER_BIT]) begin
				next_main_irq_request = main_irq_request | {1'b0, wbyte[6:0]}; // [RULE1] [RULE25]
			end else begin
				next_main_irq_request = main_irq_request & ~{1'b0, wbyte[6:0]}; // [RULE1] [RULE25]
			end
		end
		if (wr_byte && wb_adr_i == `OFS_AUX_IRQ_REQUEST) begin
			if (wbyte[`MARKER_BIT]) begin
				next_aux_irq_request = aux_irq_request | (wbyte & `AUX_VALID_MASK); // [RULE2] [RULE25]
			end else begin
				next_aux_irq_request = aux_irq_request & ~(wbyte & `AUX_VALID_MASK); // [RULE2] [RULE25]
			end
		end
		if (wr_byte && wb_adr_i == `OFS_MAIN_IRQ_ENABLE) begin
			next_main_irq_enable = wbyte;
		end
		if (wr_byte && wb_adr_i == `OFS_AUX_IRQ_ENABLE) begin
			next_aux_irq_enable = wbyte & (`AUX_VALID_MASK | 8'h80);
		end
		if (tx_last_bit_sent) begin
			next_main_irq_request[`MAIN_TX_BIT] = 1'b1; // [RULE3]
		end
		if (rx_valid_end && (!rx_require_data_option || fifo_has_data)) begin
			next_main_irq_request[`MAIN_RX_BIT] = 1'b1; // [RULE4] [RULE5]
		end
		if (command_done && active_command != `CMD_IDLE) begin
			next_main_irq_request[`MAIN_IDLE_BIT] = 1'b1; // [RULE6]
			next_force_idle = 1'b1; // [RULE6]
		end
		if (command_start && started_command != `CMD_IDLE && !started_command_known) begin
			next_main_irq_request[`MAIN_IDLE_BIT] = 1'b1; // [RULE7] [RULE8]
			next_force_idle = 1'b1; // [RULE7]
		end
		if (fifo_high_status && !prev_high) begin
			next_main_irq_request[`MAIN_HI_BIT] = 1'b1; // [RULE9]
		end
		if (fifo_low_status && !prev_low) begin
			next_main_irq_request[`MAIN_LO_BIT] = 1'b1; // [RULE10]
		end
		if (|error_status) begin
			next_main_irq_request[`MAIN_ERR_BIT] = 1'b1; // [RULE11]
		end
		if (timer_reached_zero) begin
			next_main_irq_request[`MAIN_TIMER_BIT] = 1'b1; // [RULE12]
		end
		if (contactless_serial_input_edge) begin
			next_aux_irq_request[`AUX_EDGE_BIT] = 1'b1; // [RULE13]
		end
		if (checksum_compute_command && checksum_all_processed) begin
			next_aux_irq_request[`AUX_CRC_BIT] = 1'b1; // [RULE14]
		end
		next_main_irq_request[`MARKER_BIT] = 1'b0; // [RULE26]
		next_aux_irq_request = next_aux_irq_request & `AUX_VALID_MASK; // [RULE26]
	end

	// Bus answer one cycle after the request.
	always_comb begin
		next_ack = access;
		next_rdata = 32'h0000_0000;
		if (access && !wb_we_i) begin
			case (wb_adr_i)
				`OFS_MAIN_IRQ_ENABLE: next_rdata[7:0] = main_irq_enable;
				`OFS_AUX_IRQ_ENABLE: next_rdata[7:0] = aux_irq_enable;
				`OFS_MAIN_IRQ_REQUEST: next_rdata[7:0] = main_irq_request;
				`OFS_AUX_IRQ_REQUEST: next_rdata[7:0] = aux_irq_request;
				`OFS_ERROR_STATUS: next_rdata[7:0] = error_status;
				`OFS_IRQ_STATUS: next_rdata[`STATUS_IRQ_BIT] = irq_combined;
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// Pin outputs are registered so that a glitch in the request logic never reaches a pin.
	// The antenna goes off on the same edge that sets the error bit, and stays off while the alarm or that bit is present.
	always_comb begin
		next_drivers_off = heat || error_status[`ERR_HEAT_BIT]; // [RULE16]
		next_pin = irq_combined ^ main_irq_enable[`INVERT_BIT]; // [RULE24]
	end

	// Synchronisers and level history.
	// The edge detector stays blind while the chain fills after reset, so an input that idles
	// high raises no false edge; a real edge in those first cycles is missed as the trade-off.
	always_comb begin
		next_contactless_serial_input_sync = {contactless_serial_input_sync[1:0], contactless_serial_input};
		next_heat_sync = {heat_sync[0], overheat_alarm};
		next_prev_high = fifo_high_status;
		next_prev_low = fifo_low_status;
		next_edge_hold = edge_hold;
		if (edge_hold != `ZERO_HOLD) begin
			next_edge_hold = edge_hold - `ONE_HOLD;
		end
	end

	// Error group.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			error_status <= `ZERO_BYTE;
		end else begin
			error_status <= next_error_status;
		end
	end

	// Request and enable group.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			main_irq_request <= `MAIN_REQ_RESET;
			aux_irq_request <= `ZERO_BYTE;
			main_irq_enable <= `MAIN_EN_RESET;
			aux_irq_enable <= `ZERO_BYTE;
			force_idle <= 1'b0;
		end else begin
			main_irq_request <= next_main_irq_request;
			aux_irq_request <= next_aux_irq_request;
			main_irq_enable <= next_main_irq_enable;
			aux_irq_enable <= next_aux_irq_enable;
			force_idle <= next_force_idle;
		end
	end

	// Bus group.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack <= 1'b0;
			rdata <= 32'h0000_0000;
		end else begin
			ack <= next_ack;
			rdata <= next_rdata;
		end
	end

	// Pin group.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			drivers_off <= 1'b0;
			pin <= 1'b1;
		end else begin
			drivers_off <= next_drivers_off;
			pin <= next_pin;
		end
	end

	// Synchroniser group.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			contactless_serial_input_sync <= 3'h0;
			heat_sync <= 2'h0;
			prev_high <= 1'b0;
			prev_low <= 1'b0;
			edge_hold <= `EDGE_SETTLE;
		end else begin
			contactless_serial_input_sync <= next_contactless_serial_input_sync;
			heat_sync <= next_heat_sync;
			prev_high <= next_prev_high;
			prev_low <= next_prev_low;
			edge_hold <= next_edge_hold;
		end
	end

	assign wb_ack_o = ack;
	assign wb_dat_o = rdata;
	assign force_idle_command = force_idle;
	assign antenna_driver_off = drivers_off;
	assign irq_pin = pin;

endmodule : irq_and_error_status

/* testbench/irq_and_error_status_checker.sv */
// Port-level assertion checker for the request and error block.
`timescale 1ns/1ps
module irq_and_error_status_checker (
	// Clock, reset and bus.
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Sequencer and pins.
	input wire logic command_start,
	input wire logic [3:0] started_command,
	input wire logic started_command_known,
	input wire logic command_done,
	input wire logic [3:0] active_command,
	input wire logic overheat_alarm,
	input wire logic force_idle_command,
	input wire logic antenna_driver_off
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	property p_take; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_take: assert property (p_take) else $error("ack missing");
	property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_pulse: assert property (p_pulse) else $error("ack held");
	property p_upper; wb_ack_o |-> wb_dat_o[31:8] == 24'h000000; endproperty
	a_upper: assert property (p_upper) else $error("upper data set");
	property p_aux;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == 8'h05
			|=> (wb_dat_o[7:0] & 8'hEB) == 8'h00;
	endproperty
	a_aux: assert property (p_aux) else $error("aux reserved set");
	property p_done; command_done && active_command != 4'h0 |=> force_idle_command; endproperty
	a_done: assert property (p_done) else $error("no idle return");
	property p_unknown;
		command_start && started_command != 4'h0 && !started_command_known |=> force_idle_command;
	endproperty
	a_unknown: assert property (p_unknown) else $error("unknown not idled");
	property p_idle;
		command_start && started_command == 4'h0 && !command_done |=> !force_idle_command;
	endproperty
	a_idle: assert property (p_idle) else $error("idle start flagged");
	property p_heat; overheat_alarm [*4] |-> antenna_driver_off; endproperty
	a_heat: assert property (p_heat) else $error("drivers on");
endmodule : irq_and_error_status_checker
bind irq_and_error_status irq_and_error_status_checker irq_and_error_status_checker_i (
	.ref_clk(ref_clk),
	.rst_n(rst_n),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.command_start(command_start),
	.started_command(started_command),
	.started_command_known(started_command_known),
	.command_done(command_done),
	.active_command(active_command),
	.overheat_alarm(overheat_alarm),
	.force_idle_command(force_idle_command),
	.antenna_driver_off(antenna_driver_off)
);

/* testbench/tb_irq_and_error_status.sv */
// Self-checking bench for the request and error block.
`timescale 1ns/1ps
module tb_irq_and_error_status;
	logic ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i, ev, seed, exp_v;
	logic [3:0] wb_sel_i, active_command, started_command;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic fifo_has_data, rx_require_data_option, rx_checksum_enable, anticollision_active;
	logic checksum_mismatch, bad_start_of_frame, auth_byte_count_bad, fifo_high_status;
	logic fifo_low_status, host_fifo_write, internal_fifo_write, fifo_full, rf_response_window;
	logic started_command_known, card_authentication_command, checksum_compute_command;
	logic contactless_serial_input, overheat_alarm, force_idle_command, antenna_driver_off;
	logic irq_pin, rx_startup;
	irq_status_pkg::rx_rate_t rx_rate;
	int bad_count, total_checks;
	wire tx_last_bit_sent = ev[0];
	wire rx_valid_end = ev[1];
	wire timer_reached_zero = ev[2];
	wire checksum_all_processed = ev[3];
	wire command_done = ev[4];
	wire command_start = ev[5];
	wire parity_mismatch = ev[6];
	wire bit_collision_seen = ev[7];
	irq_and_error_status irq_and_error_status_i (.*);
	always #10 ref_clk = ~ref_clk;
	function automatic logic [7:0] lfsr(logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	function automatic logic [7:0] mark(logic [7:0] o, logic [7:0] w);
		return w[7] ? (o | {1'b0, w[6:0]}) : (o & ~{1'b0, w[6:0]});
	endfunction : mark
	task automatic chk(logic [7:0] g, logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic xfer(logic w, logic [7:0] a, logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= {24'h000000, d};
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) bad_count++;
		q = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge ref_clk);
	endtask : xfer
	task automatic wr(logic [7:0] a, logic [7:0] d);
		logic [7:0] q;
		xfer(1'b1, a, d, q);
	endtask : wr
	task automatic rc(logic [7:0] a, logic [7:0] e);
		logic [7:0] q;
		xfer(1'b0, a, 8'h00, q);
		chk(q, e);
	endtask : rc
	task automatic pulse(int k);
		ev[k] <= 1'b1;
		@(posedge ref_clk);
		ev <= 8'h00;
		repeat (3) @(posedge ref_clk);
	endtask : pulse
	task close_out;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : close_out
	initial begin
		#400us;
		bad_count++;
		close_out;
	end
	initial begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		bad_count = 0;
		total_checks = 0;
		wb_sel_i = 4'hF;
		started_command_known = 1'b1;
		rx_rate = irq_status_pkg::RATE_106;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, ev, active_command, started_command,
			fifo_has_data, rx_require_data_option, rx_checksum_enable, anticollision_active,
			checksum_mismatch, bad_start_of_frame, auth_byte_count_bad, fifo_high_status,
			fifo_low_status, host_fifo_write, internal_fifo_write, fifo_full, rf_response_window,
			card_authentication_command, checksum_compute_command, contactless_serial_input,
			overheat_alarm, rx_startup} = '0;
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rc(8'h02, 8'h80);
		rc(8'h03, 8'h00);
		rc(8'h04, 8'h14);
		rc(8'h05, 8'h00);
		rc(8'h06, 8'h00);
		rc(8'h30, 8'h00);
		$display("reset test done");
		seed = 8'h5B;
		exp_v = 8'h14;
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			wr(8'h04, seed);
			exp_v = mark(exp_v, seed);
			rc(8'h04, exp_v);
		end
		$display("marker test done");
		wr(8'h05, 8'hFF);
		rc(8'h05, 8'h14);
		wr(8'h05, 8'h7F);
		checksum_compute_command <= 1'b1;
		pulse(3);
		rc(8'h05, 8'h04);
		contactless_serial_input <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rc(8'h05, 8'h14);
		$display("aux test done");
		wr(8'h04, 8'h7F);
		rx_require_data_option <= 1'b1;
		pulse(0);
		pulse(1);
		pulse(2);
		rc(8'h04, 8'h41);
		fifo_has_data <= 1'b1;
		pulse(1);
		active_command <= 4'h3;
		pulse(4);
		rc(8'h04, 8'h71);
		fifo_high_status <= 1'b1;
		fifo_low_status <= 1'b1;
		@(posedge ref_clk);
		rc(8'h04, 8'h7D);
		wr(8'h04, 8'h0C);
		rc(8'h04, 8'h71);
		$display("event test done");
		wr(8'h02, 8'h01);
		@(negedge ref_clk);
		chk({7'h00, irq_pin}, 8'h01);
		@(posedge ref_clk);
		wr(8'h02, 8'h81);
		@(negedge ref_clk);
		chk({7'h00, irq_pin}, 8'h00);
		@(posedge ref_clk);
		rc(8'h07, 8'h10);
		$display("pin test done");
		wr(8'h04, 8'h7F);
		pulse(5);
		rc(8'h04, 8'h00);
		pulse(6);
		rc(8'h06, 8'h02);
		rc(8'h04, 8'h02);
		overheat_alarm <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rc(8'h06, 8'h42);
		chk({7'h00, antenna_driver_off}, 8'h01);
		overheat_alarm <= 1'b0;
		pulse(5);
		rc(8'h06, 8'h40);
		{card_authentication_command, host_fifo_write, fifo_full, rx_checksum_enable} <= 4'hF;
		{checksum_mismatch, auth_byte_count_bad} <= 2'h3;
		@(posedge ref_clk);
		{card_authentication_command, host_fifo_write, fifo_full, checksum_mismatch} <= 4'h0;
		auth_byte_count_bad <= 1'b0;
		@(posedge ref_clk);
		rc(8'h06, 8'hD5);
		pulse(5);
		rc(8'h06, 8'h40);
		anticollision_active <= 1'b1;
		rx_rate <= irq_status_pkg::RATE_212;
		pulse(7);
		rc(8'h06, 8'h40);
		rx_rate <= irq_status_pkg::RATE_106;
		pulse(7);
		rc(8'h06, 8'h48);
		rx_startup <= 1'b1;
		@(posedge ref_clk);
		rx_startup <= 1'b0;
		@(posedge ref_clk);
		rc(8'h06, 8'h40);
		wr(8'h04, 8'h7F);
		started_command <= 4'hB;
		started_command_known <= 1'b0;
		pulse(5);
		rc(8'h04, 8'h12);
		$display("error test done");
		close_out;
	end
endmodule : tb_irq_and_error_status
